// ---- include/bus_pin_params.svh ----
// Constants for the bus pin state and configuration strap block
`ifndef BUS_PIN_PARAMS_SVH
`define BUS_PIN_PARAMS_SVH

// ----------------------------------------------------------------
// AXI4-Lite register map (byte addresses)
// ----------------------------------------------------------------
`define REG_STATUS      4'h0
`define REG_CONTROL     4'h4
`define REG_SNOOP       4'h8

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define ST_ENHANCED_BIT 0
`define ST_TRIPLE_BIT   1
`define ST_LINE_WB_BIT  2
`define ST_HALT_BIT     3
`define ST_LINE_VLD_BIT 4
`define CTL_HALT_BIT    0
`define CTL_STOPCLK_BIT 1
`define CTL_RESET_VAL   32'h0000_0000
`define SNP_HIT_BIT     0
`define SNP_MOD_BIT     1
`define SNP_RESET_VAL   32'h0000_0000

// ----------------------------------------------------------------
// Core ratio encodings and strap timing
// ----------------------------------------------------------------
`define RATIO_DOUBLE    2'h2
`define RATIO_TRIPLE    2'h3
`define STRAP_HOLD_CLKS 2

`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// ---- include/bus_pin_pkg.sv ----
// Types for the bus pin state and configuration strap block
package bus_pin_pkg;

	typedef enum logic [1:0] {
		MODE_RUN,
		MODE_STOP_GRANT,
		MODE_STOP_CLOCK
	} halt_mode_t;

	// Bus cycle outputs, all active-low except address and cycle definition
	typedef struct packed {
		logic [3:0] byte_enables_n;
		logic [1:0] addr_3_2;
		logic       write_read;
		logic       mem_io;
		logic       data_code;
		logic       lock_n;
		logic       pseudo_lock_n;
		logic       address_strobe_n;
		logic       last_transfer_n;
		logic       cacheable_n;
		logic       modified_hit_n;
	} bus_out_t;

	// Output enables for the same group, high while driven
	typedef struct packed {
		logic byte_enables;
		logic addr_3_2;
		logic cycle_def;
		logic lock;
		logic pseudo_lock;
		logic address_strobe;
		logic last_transfer;
		logic cacheable;
		logic modified_hit;
	} bus_oe_t;

endpackage

// ---- rtl/bus_pin_ctrl.sv ----
// Reset straps, line policy sampling and bus output halt/hold control
//
// Functional notes
// R1: Enhanced write-back bus mode enabled only if policy select is high at reset.
// R2: Outside logic holds policy select stable two clocks around reset release.
// R3: Line fill samples policy select on first burst or plain ready.
// R4: Core ratio strap low at reset selects double core frequency.
// R5: Core ratio strap high at reset selects triple core frequency.
// R6: Voltage identification output is driven low at all times.
// R7: Halt states force strobe, locks, cacheable, modified hit high; grant follows hold.
// R8: Address hold floats A3:A2, cacheable, hit; bus hold floats more.
// R9: Held outputs keep exactly their level from before stop grant entry.
// R10: Snoop during stop grant may drive cacheable and modified hit by hit.
`timescale 1ns/1ps
`default_nettype none
`include "bus_pin_params.svh"

module bus_pin_ctrl (
	// Clock and reset
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	// Straps and line fill
	input  wire logic                  line_policy_select,
	input  wire logic                  core_ratio_strap,
	input  wire logic                  line_fill,
	input  wire logic                  burst_ready_n,
	input  wire logic                  ready_n,
	// Bus control from the core
	input  wire bus_pin_pkg::bus_out_t core_bus,
	input  wire logic                  hold_request,
	input  wire logic                  address_hold,
	input  wire logic                  snoop_address_strobe_n,
	// Bus pins
	output var  bus_pin_pkg::bus_out_t bus_pins,
	output var  bus_pin_pkg::bus_oe_t  bus_pins_oe,
	output logic                       hold_grant_ack,
	output logic                       voltage_id_out,
	// Configuration seen by the core
	output logic                       enhanced_mode,
	output logic [1:0]                 core_ratio,
	output logic                       line_write_back,
	// AXI4-Lite slave
	input  wire logic [3:0]            s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [3:0]            s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready
);

	// ------------------------------------------------------------
	// Strap capture
	// ------------------------------------------------------------
	// Straps are taken at the second edge after release, inside the window the
	// outside logic keeps stable, so a slow release edge cannot corrupt them.
	logic [1:0] rel_cnt_ff;
	logic       straps_done_ff;
	logic       enhanced_ff;
	logic       triple_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rel_cnt_ff     <= 2'h0;
			straps_done_ff <= 1'b0;
			enhanced_ff    <= 1'b0;
			triple_ff      <= 1'b0;
		end else if (!straps_done_ff) begin
			rel_cnt_ff <= rel_cnt_ff + 2'h1;
			if (rel_cnt_ff == 2'(`STRAP_HOLD_CLKS - 1)) begin
				straps_done_ff <= 1'b1;
				enhanced_ff    <= line_policy_select; // R1 R2
				triple_ff      <= core_ratio_strap; // R4 R5
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			enhanced_mode  <= 1'b0;
			core_ratio     <= `RATIO_DOUBLE;
			voltage_id_out <= 1'b0;
		end else begin
			enhanced_mode  <= enhanced_ff; // R1
			core_ratio     <= triple_ff ? `RATIO_TRIPLE : `RATIO_DOUBLE; // R4 R5
			voltage_id_out <= 1'b0; // R6
		end
	end

	// ------------------------------------------------------------
	// Line policy sampling
	// ------------------------------------------------------------
	logic first_rdy_seen_ff;
	logic line_valid_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			first_rdy_seen_ff <= 1'b0;
			line_write_back   <= 1'b0;
			line_valid_ff     <= 1'b0;
		end else if (!line_fill) begin
			first_rdy_seen_ff <= 1'b0;
		end else if (!first_rdy_seen_ff && (!burst_ready_n || !ready_n)) begin
			first_rdy_seen_ff <= 1'b1;
			// Write-through only lines unless enhanced mode is on
			line_write_back   <= line_policy_select & enhanced_ff; // R3 R1
			line_valid_ff     <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	logic [31:0]             control_ff;
	logic [31:0]             snoop_ff;
	bus_pin_pkg::halt_mode_t mode_ff;
	bus_pin_pkg::bus_out_t   frozen_ff;
	logic                    halted;

	assign halted = (mode_ff != bus_pin_pkg::MODE_RUN);

	// Control bit 0 requests stop grant; once there, setting control bit 1 with it
	// still set moves on to stop clock. Clearing bit 0 returns to run.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_ff <= bus_pin_pkg::MODE_RUN;
		end else begin
			case (mode_ff)
				bus_pin_pkg::MODE_RUN: begin
					if (control_ff[`CTL_HALT_BIT])
						mode_ff <= bus_pin_pkg::MODE_STOP_GRANT;
				end
				bus_pin_pkg::MODE_STOP_GRANT: begin
					if (!control_ff[`CTL_HALT_BIT])
						mode_ff <= bus_pin_pkg::MODE_RUN;
					else if (control_ff[`CTL_STOPCLK_BIT])
						mode_ff <= bus_pin_pkg::MODE_STOP_CLOCK;
				end
				bus_pin_pkg::MODE_STOP_CLOCK: begin
					if (!control_ff[`CTL_HALT_BIT])
						mode_ff <= bus_pin_pkg::MODE_RUN;
				end
				default: mode_ff <= bus_pin_pkg::MODE_RUN;
			endcase
		end
	end

	// Capture the last driven levels on stop grant entry
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			frozen_ff <= '1;
		end else if (!halted) begin
			frozen_ff <= core_bus; // R9
		end
	end

	// ------------------------------------------------------------
	// Bus pin drive
	// ------------------------------------------------------------
	logic snoop_now;
	assign snoop_now = !snoop_address_strobe_n && enhanced_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bus_pins       <= '1;
			hold_grant_ack <= 1'b0;
		end else begin
			hold_grant_ack <= hold_request; // R7
			if (halted) begin
				bus_pins                  <= frozen_ff; // R9
				bus_pins.address_strobe_n <= 1'b1; // R7
				bus_pins.lock_n           <= 1'b1; // R7
				bus_pins.pseudo_lock_n    <= 1'b1; // R7
				// Snoop answers come from the snoop register during stop grant only
				bus_pins.cacheable_n      <= !(snoop_now && mode_ff == bus_pin_pkg::MODE_STOP_GRANT
				                               && snoop_ff[`SNP_HIT_BIT]); // R7 R10
				bus_pins.modified_hit_n   <= !(snoop_now && mode_ff == bus_pin_pkg::MODE_STOP_GRANT
				                               && snoop_ff[`SNP_MOD_BIT]); // R7 R10
			end else begin
				bus_pins               <= core_bus;
				// Pseudo-lock is never asserted in enhanced mode
				bus_pins.pseudo_lock_n <= core_bus.pseudo_lock_n | enhanced_ff;
				bus_pins.modified_hit_n <= core_bus.modified_hit_n | !enhanced_ff;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bus_pins_oe <= '1;
		end else begin
			bus_pins_oe.addr_3_2       <= !(address_hold || hold_request); // R8
			bus_pins_oe.cacheable      <= !(address_hold || hold_request); // R8
			bus_pins_oe.modified_hit   <= !(address_hold || hold_request); // R8
			bus_pins_oe.byte_enables   <= !hold_request; // R8
			bus_pins_oe.cycle_def      <= !hold_request; // R8
			bus_pins_oe.lock           <= !hold_request; // R8
			bus_pins_oe.pseudo_lock    <= !hold_request; // R8
			bus_pins_oe.address_strobe <= !hold_request; // R8
			bus_pins_oe.last_transfer  <= !hold_request; // R8
		end
	end

	// ------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------
	logic aw_hold_ff;
	logic w_hold_ff;
	logic [3:0]  awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0]  wstrb_ff;
	logic        do_write;

	assign do_write = aw_hold_ff && w_hold_ff && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_ff    <= 1'b0;
			w_hold_ff     <= 1'b0;
			awaddr_ff     <= 4'h0;
			wdata_ff      <= 32'h0000_0000;
			wstrb_ff      <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end else begin
			s_axi_awready <= !aw_hold_ff && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !w_hold_ff && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_ff <= 1'b1;
				awaddr_ff  <= s_axi_awaddr;
			end else if (do_write) begin
				aw_hold_ff <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_ff <= 1'b1;
				wdata_ff  <= s_axi_wdata;
				wstrb_ff  <= s_axi_wstrb;
			end else if (do_write) begin
				w_hold_ff <= 1'b0;
			end
		end
	end

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i])
				res[i*8 +: 8] = dat[i*8 +: 8];
		end
		return res;
	endfunction

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			control_ff   <= `CTL_RESET_VAL;
			snoop_ff     <= `SNP_RESET_VAL;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= `RESP_OKAY;
			case (awaddr_ff)
				`REG_CONTROL: control_ff <= merge(control_ff, wdata_ff, wstrb_ff);
				`REG_SNOOP:   snoop_ff   <= merge(snoop_ff, wdata_ff, wstrb_ff);
				`REG_STATUS:  s_axi_bresp <= `RESP_OKAY;
				default:      s_axi_bresp <= `RESP_SLVERR;
			endcase
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `RESP_OKAY;
				s_axi_rdata  <= 32'h0000_0000;
				case (s_axi_araddr)
					`REG_STATUS: begin
						s_axi_rdata[`ST_ENHANCED_BIT] <= enhanced_ff;
						s_axi_rdata[`ST_TRIPLE_BIT]   <= triple_ff;
						s_axi_rdata[`ST_LINE_WB_BIT]  <= line_write_back;
						s_axi_rdata[`ST_HALT_BIT]     <= halted;
						s_axi_rdata[`ST_LINE_VLD_BIT] <= line_valid_ff;
					end
					`REG_CONTROL: s_axi_rdata <= control_ff;
					`REG_SNOOP:   s_axi_rdata <= snoop_ff;
					default:      s_axi_rresp <= `RESP_SLVERR;
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule
`default_nettype wire

// ---- testbench/bus_ctl_model.sv ----
// External bus controller model: straps and line fills
`timescale 1ns/1ps
`default_nettype none
module bus_ctl_model (
	// Clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// Bench controls
	input  wire logic       strap_pol,
	input  wire logic       strap_ratio,
	input  wire logic       fill_go,
	input  wire logic       fill_wb,
	input  wire logic [1:0] wait_clks,
	output logic            fill_done,
	// Pins toward the block
	output logic            line_policy_select,
	output logic            core_ratio_strap,
	output logic            line_fill,
	output logic            burst_ready_n,
	output logic            ready_n
);
	logic [2:0] since_ff;
	logic [3:0] step_ff;
	logic       first_w;
	always_ff @(posedge aclk) begin
		if (!aresetn) since_ff <= 3'h0;
		else if (since_ff != 3'h7) since_ff <= since_ff + 3'h1;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) step_ff <= 4'h0;
		else if (step_ff == 4'h0) step_ff <= {3'h0, fill_go};
		else if (step_ff == {2'h0, wait_clks} + 4'h4) step_ff <= 4'h0;
		else step_ff <= step_ff + 4'h1;
	end
	// Odd wait counts open with a burst ready, even ones with a plain ready
	assign first_w = step_ff == {2'h0, wait_clks} + 4'h1;
	assign ready_n = !(first_w && !wait_clks[0]);
	assign burst_ready_n = !(step_ff > {2'h0, wait_clks} && ready_n);
	assign line_fill = step_ff != 4'h0;
	assign fill_done = step_ff == 4'h0;
	assign core_ratio_strap = strap_ratio;
	// Strap held past the capture edge, then the pin's pull-down wins between fills
	assign line_policy_select = (!aresetn || since_ff < 3'h4) ? strap_pol : first_w & fill_wb;
endmodule
`default_nettype wire

// ---- testbench/bus_pin_ctrl_sva.sv ----
// Port assertions for the bus pin control block
`timescale 1ns/1ps
`default_nettype none
`include "bus_pin_params.svh"
module bus_pin_ctrl_sva (
	// Clock and reset
	input wire logic                 aclk,
	input wire logic                 aresetn,
	// Straps, fill and hold requests
	input wire logic                 line_policy_select,
	input wire logic                 core_ratio_strap,
	input wire logic                 line_fill,
	input wire logic                 burst_ready_n,
	input wire logic                 ready_n,
	input wire logic                 hold_request,
	input wire logic                 address_hold,
	// Outputs
	input wire bus_pin_pkg::bus_oe_t bus_pins_oe,
	input wire logic                 hold_grant_ack,
	input wire logic                 voltage_id_out,
	input wire logic                 enhanced_mode,
	input wire logic [1:0]           core_ratio,
	input wire logic                 line_write_back
);
	logic [1:0] edges_ff;
	logic       pol_ff;
	logic       ratio_ff;
	logic       taken_ff;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	always_ff @(posedge aclk) begin
		if (!aresetn) edges_ff <= 2'h0;
		else if (edges_ff != 2'h3) edges_ff <= edges_ff + 2'h1;
	end
	always_ff @(posedge aclk) begin
		if (aresetn && edges_ff == 2'h1) begin
			pol_ff <= line_policy_select;
			ratio_ff <= core_ratio_strap;
		end
	end
	// Only the first ready of a fill may decide the line policy
	always_ff @(posedge aclk) begin
		if (!aresetn || !line_fill) taken_ff <= 1'b0;
		else if (!burst_ready_n || !ready_n) taken_ff <= 1'b1;
	end
	a_volt_low: assert property (voltage_id_out == 1'b0) else $error("voltage id not low");
	a_mode_strap: assert property (edges_ff == 2'h3 |-> enhanced_mode == pol_ff) else $error("mode strap");
	a_ratio_strap: assert property (edges_ff == 2'h3 |-> core_ratio == (ratio_ff ? `RATIO_TRIPLE : `RATIO_DOUBLE))
		else $error("ratio strap");
	a_line_policy: assert property (line_fill && !taken_ff && !(burst_ready_n && ready_n)
		|=> line_write_back == ($past(line_policy_select) && enhanced_mode)) else $error("line policy");
	a_grant_follow: assert property ($past(aresetn) |-> hold_grant_ack == $past(hold_request)) else $error("grant");
	a_bus_float: assert property (hold_request |=> bus_pins_oe == 9'h000) else $error("bus hold float");
	a_addr_float: assert property (address_hold |=> !bus_pins_oe.addr_3_2 && !bus_pins_oe.cacheable
		&& !bus_pins_oe.modified_hit) else $error("address hold float");
	a_driven_free: assert property (!hold_request && !address_hold |=> bus_pins_oe == 9'h1ff) else $error("oe");
endmodule
bind bus_pin_ctrl bus_pin_ctrl_sva i_bus_pin_ctrl_sva (.*);
`default_nettype wire

// ---- testbench/test_bus_pin_ctrl.sv ----
// Self-checking bench for the bus pin control block
`timescale 1ns/1ps
`default_nettype none
`include "bus_pin_params.svh"
module test_bus_pin_ctrl;
	logic                  aclk, aresetn, line_policy_select, core_ratio_strap, line_fill, burst_ready_n, ready_n;
	logic                  hold_request, address_hold, snoop_address_strobe_n, hold_grant_ack, voltage_id_out;
	logic                  enhanced_mode, line_write_back, strap_pol, strap_ratio, fill_go, fill_wb, fill_done;
	logic [1:0]            core_ratio, wait_clks, s_axi_bresp, s_axi_rresp, resp;
	logic [3:0]            s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
	logic [31:0]           s_axi_wdata, s_axi_rdata, rd;
	logic                  s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic                  s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	bus_pin_pkg::bus_out_t core_bus, bus_pins, cap, prev;
	bus_pin_pkg::bus_oe_t  bus_pins_oe;
	int                    fails = 0, checked = 0, cyc = 0, seed = 86882;
	bus_pin_ctrl i_bus_pin_ctrl (.*);
	bus_ctl_model i_bus_ctl_model (.*);
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	task automatic conclude();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [3:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		rd = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	function automatic logic [31:0] status(input logic wb, input logic halt, input logic vld);
		return {27'h0, vld, halt, wb, strap_ratio, strap_pol};
	endfunction
	// Core levels change every cycle so held pins are told apart from followed ones
	always @(posedge aclk) begin
		core_bus <= bus_pin_pkg::bus_out_t'(15'($random(seed)));
		cyc++;
		if (cyc == 4000) begin
			fails++;
			conclude();
		end
	end
	initial begin
		{aresetn, fill_go, fill_wb, hold_request, address_hold, strap_pol, strap_ratio} = 7'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, wait_clks} = 42'h0;
		snoop_address_strobe_n = 1'b1;
		s_axi_wstrb = 4'hf;
		for (int i = 0; i < 4; i++) begin
			aresetn <= 1'b0;
			strap_pol <= i[0];
			strap_ratio <= i[1];
			repeat (5) @(posedge aclk);
			aresetn <= 1'b1;
			repeat (6) @(posedge aclk);
			chk("mode", 32'(strap_pol), 32'(enhanced_mode));
			chk("ratio", 32'(strap_ratio ? `RATIO_TRIPLE : `RATIO_DOUBLE), 32'(core_ratio));
			axi_rd(`REG_STATUS);
			chk("status", status(1'b0, 1'b0, 1'b0), rd);
			wait_clks <= 2'($random(seed));
			fill_wb <= 1'($random(seed));
			fill_go <= 1'b1;
			@(posedge aclk);
			fill_go <= 1'b0;
			do @(posedge aclk); while (!fill_done);
			repeat (2) @(posedge aclk);
			chk("line_wb", 32'(fill_wb & strap_pol), 32'(line_write_back));
		end
		axi_rd(4'hc);
		chk("unmapped", 32'(`RESP_SLVERR), 32'(resp));
		chk("unmapped_data", 32'h0, rd);
		axi_wr(`REG_STATUS, 32'hffff_ffff);
		chk("ro_write", 32'(`RESP_OKAY), 32'(resp));
		axi_wr(`REG_CONTROL, 32'h1);
		// Core levels taken at the entry edge are the last ones driven before halt;
		// strobe, locks, cacheable and modified hit must read high, the rest hold
		cap = bus_pin_pkg::bus_out_t'(core_bus | 15'h003b);
		repeat (3) @(posedge aclk);
		repeat (6) begin
			@(posedge aclk);
			chk("halt_pins", 32'(cap), 32'(bus_pins));
			chk("volt_id", 32'h0, 32'(voltage_id_out));
		end
		axi_rd(`REG_STATUS);
		chk("halt_status", status(fill_wb & strap_pol, 1'b1, 1'b1), rd);
		// Snoop in stop grant answers from the snoop register, stop clock does not
		axi_wr(`REG_SNOOP, 32'h3);
		snoop_address_strobe_n <= 1'b0;
		repeat (2) @(posedge aclk);
		chk("snoop_hit", 32'h0, 32'({bus_pins.cacheable_n, bus_pins.modified_hit_n}));
		axi_wr(`REG_CONTROL, 32'h3);
		repeat (2) @(posedge aclk);
		chk("stopclk_hit", 32'h3, 32'({bus_pins.cacheable_n, bus_pins.modified_hit_n}));
		snoop_address_strobe_n <= 1'b1;
		axi_wr(`REG_CONTROL, 32'h0);
		@(posedge aclk);
		prev = core_bus;
		repeat (40) begin
			@(posedge aclk);
			// Enhanced mode is on here, so pseudo-lock reads inactive
			chk("run_pins", 32'(prev | 15'h0010), 32'(bus_pins));
			prev = core_bus;
			hold_request <= 1'($random(seed));
			address_hold <= 1'($random(seed));
		end
		hold_request <= 1'b1;
		repeat (2) @(posedge aclk);
		chk("grant", 32'h1, 32'(hold_grant_ack));
		chk("hold_oe", 32'h0, 32'(bus_pins_oe));
		conclude();
	end
endmodule
`default_nettype wire
